// ### link_enh_pkg.sv
// Package with offsets, field positions, reset values and helpers of the register bank.
package link_enh_pkg;
   localparam int          CFG_ADDR_W          = 8;
   localparam logic [7:0]  LINK_ENH_OFFSET     = 8'hF4;
   localparam logic [7:0]  SUBSYS_ALIAS_OFFSET = 8'hF8;
   localparam logic [7:0]  VENDOR_RO_OFFSET    = 8'hFC;
   localparam int          TS_STAMP_BIT        = 10;
   localparam int          VIDEO_STAMP_BIT     = 8;
   localparam int          PRIO_ARB_BIT        = 7;
   localparam int          RSVD_RW_BIT         = 2;
   localparam int          ACCEL_BIT           = 1;
   localparam int          SUBSYS_DEV_LSB      = 16;
   localparam int          SUBSYS_MAKER_LSB    = 0;
   localparam logic [31:0] LINK_ENH_RW_MASK    = 32'h0000_0586;
   localparam logic [31:0] SUBSYS_RW_MASK      = 32'hFFFF_FFFF;
   localparam logic [31:0] LINK_ENH_RESET      = 32'h0000_0000;
   localparam logic [31:0] SUBSYS_RESET        = 32'h0000_0000;
   localparam logic [31:0] VENDOR_RO_VALUE     = 32'h0000_0000;
   localparam logic [5:0]  FMT_MPEG            = 6'h20;
   localparam logic [5:0]  FMT_DV              = 6'h00;
   localparam int          PIN_SYNC_STAGES     = 3;
   localparam int          RST_SYNC_STAGES     = 2;

   typedef enum logic [1:0] {SEL_NONE, SEL_LINK_ENH, SEL_SUBSYS, SEL_VENDOR} reg_sel_t;

   // Replaces the enabled byte lanes of the writable bits only.
   function automatic logic [31:0] merge_bytes(input logic [31:0] cur,
                                               input logic [31:0] wr,
                                               input logic [3:0]  be,
                                               input logic [31:0] mask);
      logic [31:0] lane;
      lane = 32'h0000_0000;
      for (int i = 0; i < 4; i++) begin
         lane[i*8 +: 8] = {8{be[i]}};
      end
      lane = lane & mask;
      return (cur & ~lane) | (wr & lane);
   endfunction
endpackage

// ### cfg_req_if.sv
// Interface carrying one decoded configuration access between the bank modules.
`timescale 1ns/1ps
`default_nettype none
interface cfg_req_if;
   import link_enh_pkg::*;
   logic        wr;
   logic        rd;
   reg_sel_t    sel;
   logic [31:0] wdata;
   logic [3:0]  be;
   modport decoder (output wr, output rd, output sel, output wdata, output be);
   modport bank    (input wr, input rd, input sel, input wdata, input be);
endinterface
`default_nettype wire

// ### cfg_decode.sv
// Address decoder that turns a raw configuration access into a register select.
`timescale 1ns/1ps
`default_nettype none
module cfg_decode (
   input  wire logic                              wr_in,
   input  wire logic                              rd_in,
   input  wire logic [link_enh_pkg::CFG_ADDR_W-1:0] addr_in,
   input  wire logic [31:0]                       wdata_in,
   input  wire logic [3:0]                        be_in,
   cfg_req_if.decoder                             req
);
   import link_enh_pkg::*;

   logic [7:0] word_addr;

   assign word_addr = {addr_in[7:2], 2'b00};
   assign req.wr    = wr_in & ~rd_in;
   assign req.rd    = rd_in;
   assign req.wdata = wdata_in;
   assign req.be    = be_in;

   always_comb begin
      unique case (word_addr)
         LINK_ENH_OFFSET:     req.sel = SEL_LINK_ENH;
         SUBSYS_ALIAS_OFFSET: req.sel = SEL_SUBSYS;
         VENDOR_RO_OFFSET:    req.sel = SEL_VENDOR;
         default:             req.sel = SEL_NONE;
      endcase
   end
endmodule
`default_nettype wire

// ### stream_stamp_select.sv
// Decides per transmit stream whether the timestamp enhancement applies.
`timescale 1ns/1ps
`default_nettype none
module stream_stamp_select #(
   parameter int FMT_W = 6
) (
   input  wire logic             clk_in,
   input  wire logic             rst_b_in,
   input  wire logic             clear_in,
   input  wire logic             mpeg_on_in,
   input  wire logic             dv_on_in,
   input  wire logic             fmt_valid_in,
   input  wire logic [FMT_W-1:0] fmt_in,
   output logic                  apply_q_out
);
   import link_enh_pkg::*;

   generate
      if (FMT_W != 6) begin : g_bad_width
         $error("stream_stamp_select: format code must be 6 bits wide.");
      end
   endgenerate

   logic apply_d;

   always_comb begin
      apply_d = 1'b0;
      if (fmt_valid_in) begin
         if (mpeg_on_in && fmt_in == FMT_MPEG) begin
            apply_d = 1'b1;
         end
         if (dv_on_in && fmt_in == FMT_DV) begin
            apply_d = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         apply_q_out <= 1'b0;
      end else if (clear_in) begin
         apply_q_out <= 1'b0;
      end else begin
         apply_q_out <= apply_d;
      end
   end
endmodule
`default_nettype wire

// ### link_enhance_subsys_regs.sv
// Configuration register bank: link enhancement bits, subsystem alias and read-only word.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Bit 10 RW, stamps transport streams format 20h
// - Bit 8 RW, stamps video streams format 00h
// - Bit 7 RW, enables priority arbitration responses
// - Bit 1 RW, tells PHY acceleration supported
// - Reserved bits 11,9,6-3,0 read zero
// - Three reset sources restore writable defaults
// - Alias write loads subsystem IDs, reads back
// - Upper half device code, lower maker code
// - Read-only word at FCh reads zero
module link_enhance_subsys_regs #(
   parameter int FMT_W = 6
) (
   input  wire logic                              clk_in,
   input  wire logic                              rst_b_in,
   input  wire logic                              pcie_fund_reset_b_in,
   input  wire logic                              global_reset_input_b_in,
   input  wire logic                              cfg_wr_in,
   input  wire logic                              cfg_rd_in,
   input  wire logic [link_enh_pkg::CFG_ADDR_W-1:0] cfg_addr_in,
   input  wire logic [31:0]                       cfg_wdata_in,
   input  wire logic [3:0]                        cfg_be_in,
   input  wire logic                              tx_fmt_valid_in,
   input  wire logic [FMT_W-1:0]                  tx_fmt_in,
   output logic [31:0]                            cfg_rdata_out,
   output logic                                   cfg_rd_ack_out,
   output logic                                   cfg_wr_ack_out,
   output logic                                   transport_stream_stamp_on_out,
   output logic                                   video_stream_stamp_on_out,
   output logic                                   priority_arb_on_out,
   output logic                                   accel_support_to_phy_out,
   output logic                                   stamp_apply_out,
   output logic [15:0]                            subsystem_device_code_out,
   output logic [15:0]                            subsystem_maker_code_out,
   output logic                                   subsystem_id_load_out
);
   import link_enh_pkg::*;

   logic [RST_SYNC_STAGES-1:0] rst_sync_q;
   logic                       rst_sync_b;
   logic [PIN_SYNC_STAGES-1:0] pcie_sync_q;
   logic [PIN_SYNC_STAGES-1:0] global_reset_input_sync_q;
   logic                       pcie_level_q;
   logic                       global_reset_input_level_q;
   logic                       soft_clear;
   logic [31:0]                link_enh_q;
   logic [31:0]                link_enh_d;
   logic [31:0]                subsys_q;
   logic [31:0]                subsys_d;
   logic [31:0]                rdata_d;
   logic                       link_wr;
   logic                       subsys_wr;

   cfg_req_if req ();

   cfg_decode u_decode (
      .wr_in    (cfg_wr_in),
      .rd_in    (cfg_rd_in),
      .addr_in  (cfg_addr_in),
      .wdata_in (cfg_wdata_in),
      .be_in    (cfg_be_in),
      .req      (req.decoder)
   );

   // Power-on reset is released through two flip-flops.
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rst_sync_q <= '0;
      end else begin
         rst_sync_q <= {rst_sync_q[RST_SYNC_STAGES-2:0], 1'b1};
      end
   end
   assign rst_sync_b = rst_sync_q[RST_SYNC_STAGES-1];

   // Reset pins pass three flip-flops; a level counts once the last two agree.
   always_ff @(posedge clk_in or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         pcie_sync_q <= '1;
         global_reset_input_sync_q <= '1;
      end else begin
         pcie_sync_q <= {pcie_sync_q[PIN_SYNC_STAGES-2:0], pcie_fund_reset_b_in};
         global_reset_input_sync_q <= {global_reset_input_sync_q[PIN_SYNC_STAGES-2:0], global_reset_input_b_in};
      end
   end

   always_ff @(posedge clk_in or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         pcie_level_q <= 1'b1;
         global_reset_input_level_q <= 1'b1;
      end else begin
         if (pcie_sync_q[1] == pcie_sync_q[2]) begin
            pcie_level_q <= pcie_sync_q[2];
         end
         if (global_reset_input_sync_q[1] == global_reset_input_sync_q[2]) begin
            global_reset_input_level_q <= global_reset_input_sync_q[2];
         end
      end
   end

   assign soft_clear = ~pcie_level_q | ~global_reset_input_level_q;

   assign link_wr   = req.wr && req.sel == SEL_LINK_ENH;
   assign subsys_wr = req.wr && req.sel == SEL_SUBSYS;

   // Only the writable bits in enabled byte lanes take write data; every other bit keeps its value.
   assign link_enh_d = merge_bytes(link_enh_q, req.wdata, req.be, LINK_ENH_RW_MASK);
   assign subsys_d   = merge_bytes(subsys_q, req.wdata, req.be, SUBSYS_RW_MASK);

   always_ff @(posedge clk_in or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         link_enh_q <= LINK_ENH_RESET;
      end else if (soft_clear) begin
         link_enh_q <= LINK_ENH_RESET;
      end else if (link_wr) begin
         link_enh_q <= link_enh_d;
      end
   end

   always_ff @(posedge clk_in or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         subsys_q <= SUBSYS_RESET;
      end else if (soft_clear) begin
         subsys_q <= SUBSYS_RESET;
      end else if (subsys_wr) begin
         subsys_q <= subsys_d;
      end
   end

   // Subsystem identification copies and their load pulse.
   always_ff @(posedge clk_in or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         subsystem_device_code_out <= SUBSYS_RESET[31:16];
         subsystem_maker_code_out  <= SUBSYS_RESET[15:0];
         subsystem_id_load_out     <= 1'b0;
      end else if (soft_clear) begin
         subsystem_device_code_out <= SUBSYS_RESET[31:16];
         subsystem_maker_code_out  <= SUBSYS_RESET[15:0];
         subsystem_id_load_out     <= 1'b0;
      end else begin
         subsystem_id_load_out <= subsys_wr;
         if (subsys_wr) begin
            subsystem_device_code_out <= subsys_d[SUBSYS_DEV_LSB +: 16];
            subsystem_maker_code_out  <= subsys_d[SUBSYS_MAKER_LSB +: 16];
         end
      end
   end

   // Enable outputs follow the register bits, so they lag a write by two cycles.
   always_ff @(posedge clk_in or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         transport_stream_stamp_on_out <= 1'b0;
         video_stream_stamp_on_out     <= 1'b0;
         priority_arb_on_out           <= 1'b0;
         accel_support_to_phy_out      <= 1'b0;
      end else begin
         transport_stream_stamp_on_out <= link_enh_q[TS_STAMP_BIT];
         video_stream_stamp_on_out     <= link_enh_q[VIDEO_STAMP_BIT];
         priority_arb_on_out           <= link_enh_q[PRIO_ARB_BIT];
         accel_support_to_phy_out      <= link_enh_q[ACCEL_BIT];
      end
   end

   stream_stamp_select #(
      .FMT_W (FMT_W)
   ) u_stamp (
      .clk_in       (clk_in),
      .rst_b_in     (rst_sync_b),
      .clear_in     (soft_clear),
      .mpeg_on_in   (link_enh_q[TS_STAMP_BIT]),
      .dv_on_in     (link_enh_q[VIDEO_STAMP_BIT]),
      .fmt_valid_in (tx_fmt_valid_in),
      .fmt_in       (tx_fmt_in),
      .apply_q_out  (stamp_apply_out)
   );

   // Read data; bit 2 is stored and read back although software should leave it zero.
   always_comb begin
      unique case (req.sel)
         SEL_LINK_ENH: rdata_d = link_enh_q & LINK_ENH_RW_MASK;
         SEL_SUBSYS:   rdata_d = subsys_q;
         SEL_VENDOR:   rdata_d = VENDOR_RO_VALUE;
         SEL_NONE:     rdata_d = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         cfg_rdata_out  <= 32'h0000_0000;
         cfg_rd_ack_out <= 1'b0;
         cfg_wr_ack_out <= 1'b0;
      end else begin
         cfg_rd_ack_out <= req.rd;
         cfg_wr_ack_out <= req.wr;
         if (req.rd) begin
            cfg_rdata_out <= rdata_d;
         end
      end
   end
endmodule
`default_nettype wire

// ### link_enh_monitor.sv
// Concurrent checks on the register bank's ports.
`timescale 1ns/1ps
`default_nettype none
module link_enh_monitor
   import link_enh_pkg::*;
#(
   parameter int FMT_W = 6
) (
   input wire logic             clk_in,
   input wire logic             rst_b_in,
   input wire logic             pcie_fund_reset_b_in,
   input wire logic             global_reset_input_b_in,
   input wire logic             cfg_wr_in,
   input wire logic             cfg_rd_in,
   input wire logic [7:0]       cfg_addr_in,
   input wire logic [31:0]      cfg_wdata_in,
   input wire logic [3:0]       cfg_be_in,
   input wire logic             tx_fmt_valid_in,
   input wire logic [FMT_W-1:0] tx_fmt_in,
   input wire logic [31:0]      cfg_rdata_out,
   input wire logic             cfg_rd_ack_out,
   input wire logic             cfg_wr_ack_out,
   input wire logic             transport_stream_stamp_on_out,
   input wire logic             video_stream_stamp_on_out,
   input wire logic             priority_arb_on_out,
   input wire logic             accel_support_to_phy_out,
   input wire logic             stamp_apply_out,
   input wire logic [15:0]      subsystem_device_code_out,
   input wire logic [15:0]      subsystem_maker_code_out,
   input wire logic             subsystem_id_load_out
);
   logic wr_f4;
   logic wr_f8;
   logic pin_low;
   logic mpeg_fmt;
   logic dv_fmt;
   assign wr_f4 = cfg_wr_in && !cfg_rd_in && cfg_addr_in == LINK_ENH_OFFSET;
   assign wr_f8 = cfg_wr_in && !cfg_rd_in && cfg_addr_in == SUBSYS_ALIAS_OFFSET;
   assign pin_low = !pcie_fund_reset_b_in || !global_reset_input_b_in;
   assign mpeg_fmt = tx_fmt_valid_in && tx_fmt_in == FMT_MPEG;
   assign dv_fmt = tx_fmt_valid_in && tx_fmt_in == FMT_DV;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   // An enable output shows, one cycle on, the register bit that the stamp decision used.
   // The first cycle of a pin clear drops the stamp early, so that cycle is left out.
   mpeg_stamp_a: assert property (
      mpeg_fmt && !$past(pin_low, 3) |=> stamp_apply_out == transport_stream_stamp_on_out)
      else $error("transport stream stamp wrong");
   video_stamp_a: assert property (
      dv_fmt && !$past(pin_low, 3) |=> stamp_apply_out == video_stream_stamp_on_out)
      else $error("video stream stamp wrong");
   no_stamp_a: assert property (!mpeg_fmt && !dv_fmt |=> !stamp_apply_out)
      else $error("stamp applied without cause");
   prio_follow_a: assert property (
      wr_f4 && cfg_be_in[0] |-> ##2 priority_arb_on_out == $past(cfg_wdata_in[7], 2))
      else $error("priority output wrong");
   accel_follow_a: assert property (
      wr_f4 && cfg_be_in[0] |-> ##2 accel_support_to_phy_out == $past(cfg_wdata_in[1], 2))
      else $error("acceleration output wrong");
   reserved_zero_a: assert property (
      cfg_rd_in && cfg_addr_in == LINK_ENH_OFFSET
      |=> cfg_rd_ack_out && (cfg_rdata_out & ~LINK_ENH_RW_MASK) == 32'h0000_0000)
      else $error("reserved bits not zero");
   vendor_zero_a: assert property (
      cfg_rd_in && cfg_addr_in == VENDOR_RO_OFFSET
      |=> cfg_rd_ack_out && cfg_rdata_out == VENDOR_RO_VALUE)
      else $error("read-only word not zero");
   id_load_a: assert property (
      wr_f8 && cfg_be_in == 4'hF |=> subsystem_id_load_out
      && {subsystem_device_code_out, subsystem_maker_code_out} == $past(cfg_wdata_in))
      else $error("subsystem codes not loaded");
   pin_clear_a: assert property (
      pin_low [*8] |-> {subsystem_device_code_out, subsystem_maker_code_out} == 32'h0000_0000
      && !priority_arb_on_out && !accel_support_to_phy_out)
      else $error("pin reset left state");
   cover property (stamp_apply_out);
   cover property (subsystem_id_load_out);
   cover property (pin_low [*8]);
endmodule
bind link_enhance_subsys_regs link_enh_monitor #(.FMT_W(FMT_W)) mon (
   .clk_in(clk_in), .rst_b_in(rst_b_in), .pcie_fund_reset_b_in(pcie_fund_reset_b_in),
   .global_reset_input_b_in(global_reset_input_b_in), .cfg_wr_in(cfg_wr_in),
   .cfg_rd_in(cfg_rd_in), .cfg_addr_in(cfg_addr_in), .cfg_wdata_in(cfg_wdata_in),
   .cfg_be_in(cfg_be_in), .tx_fmt_valid_in(tx_fmt_valid_in), .tx_fmt_in(tx_fmt_in),
   .cfg_rdata_out(cfg_rdata_out), .cfg_rd_ack_out(cfg_rd_ack_out),
   .cfg_wr_ack_out(cfg_wr_ack_out), .stamp_apply_out(stamp_apply_out),
   .transport_stream_stamp_on_out(transport_stream_stamp_on_out),
   .video_stream_stamp_on_out(video_stream_stamp_on_out),
   .priority_arb_on_out(priority_arb_on_out), .accel_support_to_phy_out(accel_support_to_phy_out),
   .subsystem_device_code_out(subsystem_device_code_out),
   .subsystem_maker_code_out(subsystem_maker_code_out),
   .subsystem_id_load_out(subsystem_id_load_out));
`default_nettype wire

// ### link_stream_model.sv
// Behavioural link core presenting transmit stream format codes.
`timescale 1ns/1ps
`default_nettype none
module link_stream_model (
   input  wire logic  clk_in,
   output logic       fmt_valid_out,
   output logic [5:0] fmt_out
);
   initial begin
      fmt_valid_out = 1'b0;
      fmt_out = 6'h3F;
   end
   // The code lines are inverted once a header is gone, so no stale value lingers.
   task automatic send(input logic [5:0] fmt);
      @(posedge clk_in);
      fmt_valid_out <= 1'b1;
      fmt_out <= fmt;
      @(posedge clk_in);
      fmt_valid_out <= 1'b0;
      fmt_out <= ~fmt;
      #1;
   endtask
endmodule
`default_nettype wire

// ### link_enhance_subsys_regs_tb.sv
// Self-checking testbench for the configuration register bank.
`timescale 1ns/1ps
`default_nettype none
module link_enhance_subsys_regs_tb;
   import link_enh_pkg::*;
   localparam logic [31:0] ZERO = 32'h0000_0000;
   logic clk = 1'b0, rst_b = 1'b0, pcie_b = 1'b1, global_reset_input_b = 1'b1, wr = 1'b0, rd = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wdata = ZERO, rdata;
   logic [3:0]  be = 4'h0;
   logic [5:0]  fmt;
   logic [15:0] dev, maker;
   logic fv, rd_ack, wr_ack, ts_on, dv_on, prio_on, accel_on, stamp, id_load;
   int mismatches = 0, tests_run = 0, cycles = 0;
   always #5 clk = ~clk;
   link_stream_model link (.clk_in(clk), .fmt_valid_out(fv), .fmt_out(fmt));
   link_enhance_subsys_regs #(.FMT_W(6)) dut (.clk_in(clk), .rst_b_in(rst_b),
      .pcie_fund_reset_b_in(pcie_b), .global_reset_input_b_in(global_reset_input_b), .cfg_wr_in(wr),
      .cfg_rd_in(rd), .cfg_addr_in(addr), .cfg_wdata_in(wdata), .cfg_be_in(be),
      .tx_fmt_valid_in(fv), .tx_fmt_in(fmt), .cfg_rdata_out(rdata), .cfg_rd_ack_out(rd_ack),
      .cfg_wr_ack_out(wr_ack), .transport_stream_stamp_on_out(ts_on),
      .video_stream_stamp_on_out(dv_on), .priority_arb_on_out(prio_on),
      .accel_support_to_phy_out(accel_on), .stamp_apply_out(stamp),
      .subsystem_device_code_out(dev), .subsystem_maker_code_out(maker),
      .subsystem_id_load_out(id_load));
   task automatic report_and_stop;
      $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         report_and_stop();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic access(input logic w, input logic [7:0] a, input logic [31:0] d,
                         input logic [3:0] b);
      @(posedge clk);
      wr <= w;
      rd <= !w;
      addr <= a;
      wdata <= d;
      be <= b;
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b0;
      #1;
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
      access(1'b1, a, d, b);
      chk(wr_ack, 1'b1);
      chk(rd_ack, 1'b0);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      access(1'b0, a, ZERO, 4'h0);
      chk(rd_ack, 1'b1);
      chk(wr_ack, 1'b0);
      chk(rdata, exp);
   endtask
   task automatic stream(input logic [5:0] f, input logic e);
      link.send(f);
      chk(stamp, e);
   endtask
   initial begin
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      rd_chk(LINK_ENH_OFFSET, ZERO);
      rd_chk(SUBSYS_ALIAS_OFFSET, ZERO);
      rd_chk(VENDOR_RO_OFFSET, ZERO);
      wr_reg(LINK_ENH_OFFSET, 32'hFFFF_FFFB, 4'hF);
      rd_chk(LINK_ENH_OFFSET, 32'h0000_0582);
      chk({ts_on, dv_on, prio_on, accel_on}, 4'hF);
      stream(FMT_MPEG, 1'b1);
      stream(FMT_DV, 1'b1);
      stream(6'h01, 1'b0);
      wr_reg(LINK_ENH_OFFSET, ZERO, 4'h1);
      rd_chk(LINK_ENH_OFFSET, 32'h0000_0500);
      chk({prio_on, accel_on}, 2'b00);
      wr_reg(LINK_ENH_OFFSET, 32'h0000_0400, 4'h2);
      stream(FMT_DV, 1'b0);
      stream(FMT_MPEG, 1'b1);
      chk({ts_on, dv_on}, 2'h2);
      wr_reg(SUBSYS_ALIAS_OFFSET, 32'h1234_ABCD, 4'hF);
      chk(id_load, 1'b1);
      chk({dev, maker}, 32'h1234_ABCD);
      rd_chk(SUBSYS_ALIAS_OFFSET, 32'h1234_ABCD);
      chk(id_load, 1'b0);
      wr_reg(SUBSYS_ALIAS_OFFSET, 32'h0000_5600, 4'h2);
      rd_chk(SUBSYS_ALIAS_OFFSET, 32'h1234_56CD);
      chk({dev, maker}, 32'h1234_56CD);
      wr_reg(VENDOR_RO_OFFSET, 32'hFFFF_FFFF, 4'hF);
      rd_chk(VENDOR_RO_OFFSET, ZERO);
      rd_chk(8'h04, ZERO);
      for (int i = 0; i < 3; i++) begin
         wr_reg(LINK_ENH_OFFSET, 32'h0000_0582, 4'hF);
         wr_reg(SUBSYS_ALIAS_OFFSET, 32'h0F0F_0001, 4'hF);
         @(posedge clk);
         pcie_b <= (i != 0);
         global_reset_input_b <= (i != 1);
         rst_b <= (i != 2);
         repeat (8) @(posedge clk);
         pcie_b <= 1'b1;
         global_reset_input_b <= 1'b1;
         rst_b <= 1'b1;
         repeat (6) @(posedge clk);
         chk({dev, maker}, ZERO);
         chk({ts_on, dv_on, prio_on, accel_on}, 4'h0);
         rd_chk(LINK_ENH_OFFSET, ZERO);
         rd_chk(SUBSYS_ALIAS_OFFSET, ZERO);
      end
      report_and_stop();
   end
endmodule
`default_nettype wire
